// File: hw/ief_eeprom_front_end.sv
// two-wire eeprom slave front end with write gating and register routing
`timescale 1ns/1ps
module ief_eeprom_front_end #(
  parameter int WRITE_CYC = ief_pkg::IEF_WRITE_CYC,
  parameter int DEPTH = ief_pkg::IEF_MEM_DEPTH,
  parameter logic [3:0] REG_CODE = 4'h5 // arbitrary value
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic write_inhibit_pin_i,
  output logic sda_o,
  output logic sda_oe_o,
  output ief_pkg::ief_stat_t stat_o
);
  import ief_pkg::*;

  // parameter limits the logic can serve
  if (WRITE_CYC < 1) begin : g_bad_cyc
    $error("ief: write cycle count must be positive");
  end
  if (DEPTH < 2 || DEPTH > (1 << IEF_ADDR_W)) begin : g_bad_depth
    $error("ief: depth out of range");
  end

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_DEV_ACK, ST_AHI, ST_AHI_ACK, ST_ALO, ST_ALO_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_SKIP
  } ief_state_t;

  // oversampling keeps up with 1 MHz clock
  // synchronisers, idle levels so no false edge or inhibit
  ief_pins_t s1_reg, s2_reg, s3_reg;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s1_reg <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0};
      s2_reg <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0};
      s3_reg <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0};
    end else begin
      s1_reg <= '{scl: scl_i, sda: sda_i, wp: write_inhibit_pin_i};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = s2_reg.scl & ~s3_reg.scl;
  assign scl_fall = ~s2_reg.scl & s3_reg.scl;
  assign start_c = s2_reg.scl & s3_reg.scl & ~s2_reg.sda & s3_reg.sda;
  assign stop_c = s2_reg.scl & s3_reg.scl & s2_reg.sda & ~s3_reg.sda;

  // storage: array and registers
  logic [7:0] mem_reg [DEPTH];
  logic [7:0] acfg_reg, guard_reg;
  logic [7:0] type_reg;

  function automatic ief_tgt_t decode_tgt(input logic is_reg,
                                          input logic [2:0] sel);
    ief_tgt_t t;
    t = IEF_TGT_MEM;
    if (is_reg) begin
      case (sel)
        IEF_SEL_TYPE: t = IEF_TGT_TYPE;
        IEF_SEL_ACFG: t = IEF_TGT_ACFG;
        IEF_SEL_GUARD: t = IEF_TGT_GUARD;
        default: t = IEF_TGT_MEM;
      endcase
    end
    return t;
  endfunction

  ief_state_t st_reg;
  logic [7:0] sh_reg;
  logic [2:0] bit_reg;
  logic rd_reg, is_reg_reg, sda_low_reg;
  logic [IEF_ADDR_W-1:0] addr_reg;
  logic [7:0] wbuf_reg;
  logic wpend_reg, wmulti_reg;
  logic busy_reg, standby_reg;
  logic [31:0] wcnt_reg;
  logic wstart;
  ief_tgt_t tgt;
  logic [7:0] rd_byte;
  logic dev_seen_reg;

  // register selection uses the register code and address bits 15..13
  assign tgt = decode_tgt(is_reg_reg,
                          addr_reg[IEF_SEL_HI:IEF_SEL_LO]);

  // read mux, type register has no write path
  always_comb begin
    case (tgt)
      IEF_TGT_TYPE: rd_byte = type_reg;
      IEF_TGT_ACFG: rd_byte = acfg_reg;
      IEF_TGT_GUARD: rd_byte = guard_reg;
      default: rd_byte = mem_reg[addr_reg[IEF_ADDR_W-1:0] % DEPTH];
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      // code in bits 7..4; zeros; lock one
      type_reg <= {REG_CODE, IEF_RSVD_VAL, IEF_LOCK_VAL};
    end
  end

  // select decoded only after its eight bits
  always_ff @(posedge core_clk_i) begin
    if (rst_i || start_c || stop_c) begin
      dev_seen_reg <= 1'b0;
    end else if (scl_rise && st_reg == ST_DEV) begin
      dev_seen_reg <= 1'b1;
    end
  end

  // protocol engine
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      // reset silences bus and initialises state
      st_reg <= ST_IDLE;
      sh_reg <= 8'h00;
      bit_reg <= 3'h0;
      rd_reg <= 1'b0;
      is_reg_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      addr_reg <= '0;
      wbuf_reg <= 8'h00;
      wpend_reg <= 1'b0;
      wmulti_reg <= 1'b0;
    end else if (stop_c || start_c) begin
      sda_low_reg <= 1'b0;
      bit_reg <= 3'h0;
      st_reg <= start_c ? ST_DEV : ST_IDLE;
      if (stop_c) begin
        wpend_reg <= 1'b0;
      end
    end else if (scl_rise) begin
      // sample data on rising serial clock
      case (st_reg)
        ST_DEV, ST_AHI, ST_ALO, ST_WDATA: begin
          sh_reg <= {sh_reg[6:0], s2_reg.sda};
          bit_reg <= bit_reg + 3'h1;
        end
        ST_RDATA_ACK: begin
          if (s2_reg.sda) begin
            st_reg <= ST_SKIP;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      // launch data after falling serial clock
      case (st_reg)
        ST_DEV: begin
          if (bit_reg == 3'h0 && dev_seen_reg) begin
            rd_reg <= sh_reg[0];
            is_reg_reg <= (sh_reg[7:4] == REG_CODE);
            if ((sh_reg[7:4] == IEF_MEM_CODE ||
                 sh_reg[7:4] == REG_CODE) && !busy_reg) begin
              sda_low_reg <= 1'b1;
              st_reg <= ST_DEV_ACK;
              if (sh_reg[7:4] == IEF_MEM_CODE) begin
                addr_reg[IEF_ADDR_W-1] <= sh_reg[1];
              end
            end else begin
              st_reg <= ST_SKIP;
            end
          end
        end
        ST_DEV_ACK: begin
          sda_low_reg <= 1'b0;
          if (rd_reg) begin
            sda_low_reg <= ~rd_byte[7];
            sh_reg <= {rd_byte[6:0], 1'b0};
            st_reg <= ST_RDATA;
          end else begin
            st_reg <= ST_AHI;
          end
        end
        ST_AHI, ST_ALO: begin
          if (bit_reg == 3'h0) begin
            // address bytes acknowledged even when inhibited
            sda_low_reg <= 1'b1;
            if (st_reg == ST_AHI) begin
              addr_reg[15:8] <= sh_reg;
              st_reg <= ST_AHI_ACK;
            end else begin
              addr_reg[7:0] <= sh_reg;
              st_reg <= ST_ALO_ACK;
            end
          end
        end
        ST_AHI_ACK: begin
          sda_low_reg <= 1'b0;
          st_reg <= ST_ALO;
        end
        ST_ALO_ACK: begin
          sda_low_reg <= 1'b0;
          st_reg <= ST_WDATA;
        end
        ST_WDATA: begin
          if (bit_reg == 3'h0) begin
            // data ack only when not inhibited
            if (!s2_reg.wp) begin
              sda_low_reg <= 1'b1;
              wbuf_reg <= sh_reg;
              wmulti_reg <= wpend_reg;
              wpend_reg <= 1'b1;
              st_reg <= ST_WDATA_ACK;
            end else begin
              st_reg <= ST_SKIP;
            end
          end
        end
        ST_WDATA_ACK: begin
          sda_low_reg <= 1'b0;
          st_reg <= ST_WDATA;
        end
        ST_RDATA: begin
          bit_reg <= bit_reg + 3'h1;
          if (bit_reg == 3'h7) begin
            sda_low_reg <= 1'b0;
            st_reg <= ST_RDATA_ACK;
          end else begin
            sda_low_reg <= ~sh_reg[7];
            sh_reg <= {sh_reg[6:0], 1'b0};
          end
        end
        ST_RDATA_ACK: begin
          // register reads ignore low address bits
          if (tgt == IEF_TGT_MEM) begin
            addr_reg <= addr_reg + 1'b1;
          end
          sda_low_reg <= ~rd_byte[7];
          sh_reg <= {rd_byte[6:0], 1'b0};
          bit_reg <= 3'h0;
          st_reg <= ST_RDATA;
        end
        default: begin
        end
      endcase
    end
  end

  // stop with pending data launches write cycle
  // data still pending is dropped while inhibited
  assign wstart = stop_c && wpend_reg && !busy_reg && !s2_reg.wp &&
                  !rst_i;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      wcnt_reg <= '0;
      acfg_reg <= IEF_ACFG_RST;
      guard_reg <= IEF_GUARD_RST;
    end else if (wstart) begin
      busy_reg <= 1'b1;
      wcnt_reg <= '0;
      case (tgt)
        IEF_TGT_ACFG: begin
          if (!acfg_reg[IEF_ACFG_LOCK_BIT] && !wmulti_reg) begin
            acfg_reg <= wbuf_reg;
          end
        end
        IEF_TGT_GUARD: begin
          if (!guard_reg[IEF_GUARD_LOCK_BIT] && !wmulti_reg) begin
            guard_reg <= wbuf_reg;
          end
        end
        default: begin
        end
      endcase
    end else if (busy_reg) begin
      if (wcnt_reg == 32'(WRITE_CYC - 1)) begin
        busy_reg <= 1'b0;
      end
      wcnt_reg <= wcnt_reg + 32'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (wstart && tgt == IEF_TGT_MEM) begin
      mem_reg[addr_reg % DEPTH] <= wbuf_reg;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      standby_reg <= 1'b1;
    end else if (start_c) begin
      standby_reg <= 1'b0;
    end else if ((stop_c && !wstart && !busy_reg) || (busy_reg &&
             wcnt_reg == 32'(WRITE_CYC - 1))) begin
      standby_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      stat_o <= '0;
    end else begin
      sda_o <= 1'b0;
      sda_oe_o <= sda_low_reg;
      stat_o <= '{busy: busy_reg, standby: standby_reg,
                  inhibited: s2_reg.wp};
    end
  end
endmodule

// File: hw/ief_pkg.sv
// package: constants and types for the two-wire eeprom front end
package ief_pkg;
  localparam int IEF_ADDR_W = 17;
  localparam int IEF_MEM_DEPTH = 131072;
  localparam logic [3:0] IEF_MEM_CODE = 4'ha;
  localparam logic [2:0] IEF_SEL_TYPE = 3'h7;
  localparam logic [2:0] IEF_SEL_ACFG = 3'h6;
  localparam logic [2:0] IEF_SEL_GUARD = 3'h5;
  localparam int IEF_SEL_HI = 15;
  localparam int IEF_SEL_LO = 13;
  localparam logic [2:0] IEF_RSVD_VAL = 3'h0;
  localparam logic IEF_LOCK_VAL = 1'b1;
  localparam logic [7:0] IEF_ACFG_RST = 8'h00;
  localparam logic [7:0] IEF_GUARD_RST = 8'h00;
  localparam int IEF_ACFG_LOCK_BIT = 0;
  localparam int IEF_GUARD_LOCK_BIT = 3;
  localparam int IEF_CLK_MHZ = 100;
  localparam int IEF_WRITE_TIME_MS = 4;
  localparam int IEF_WRITE_CYC = IEF_WRITE_TIME_MS * 1000 * IEF_CLK_MHZ;
  localparam int IEF_WAKE_US = 5;
  localparam int IEF_WAKE_CYC = IEF_WAKE_US * IEF_CLK_MHZ;

  typedef enum logic [1:0] {
    IEF_TGT_MEM,
    IEF_TGT_TYPE,
    IEF_TGT_ACFG,
    IEF_TGT_GUARD
  } ief_tgt_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
  } ief_pins_t;

  typedef struct packed {
    logic busy;
    logic standby;
    logic inhibited;
  } ief_stat_t;
endpackage

// File: test/ief_efe_asserts.sv
// port checks for the eeprom front end
`timescale 1ns/1ps
module ief_efe_asserts #(
  parameter int WRITE_CYC = 400
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic write_inhibit_pin_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire ief_pkg::ief_stat_t stat_o
);
  import ief_pkg::*;
  int busy_cnt;
  default clocking dc @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !stat_o.busy) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  sda_pull_a: assert property (!sda_o)
    else $error("data driven high");
  rst_mute_a: assert property (
    disable iff (1'b0) rst_i |=> !sda_oe_o && stat_o == 3'h0)
    else $error("active in reset");
  wake_stby_a: assert property (
    $fell(rst_i) |=> stat_o.standby && !stat_o.busy)
    else $error("no standby after reset");
  busy_stby_a: assert property (stat_o.busy |-> !stat_o.standby)
    else $error("standby while busy");
  busy_max_a: assert property (busy_cnt <= WRITE_CYC)
    else $error("write cycle too long");
  busy_mute_a: assert property (stat_o.busy |-> !sda_oe_o)
    else $error("acknowledge while busy");
  inh_nowr_a: assert property (
    stat_o.inhibited |=> !$rose(stat_o.busy))
    else $error("write started while inhibited");
  inh_seen_a: assert property (
    write_inhibit_pin_i [*6] |-> stat_o.inhibited)
    else $error("inhibit not seen");
  launch_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data changed with clock high");
endmodule
bind ief_eeprom_front_end ief_efe_asserts #(.WRITE_CYC(WRITE_CYC)) i_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
  .write_inhibit_pin_i(write_inhibit_pin_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .stat_o(stat_o));

// File: test/ief_i2c_master.sv
// two-wire bus master model, open-drain data
`timescale 1ns/1ps
module ief_i2c_master (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  int slow = 0;
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic edge4(input logic a, b);
    #(50 + slow);
    sda_oe_o = a;
    #12.5;
    scl_o = 1'b1;
    #31.25;
    sda_oe_o = b;
    #31.25;
  endtask
  task automatic start();
    edge4(1'b0, 1'b1);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    edge4(1'b1, 1'b0);
  endtask
  task automatic bitx(input logic b, output logic r);
    #(50 + slow);
    sda_oe_o = !b;
    #12.5;
    scl_o = 1'b1;
    #31.25;
    r = sda_i;
    #31.25;
    scl_o = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, d[i]);
    end
    bitx(1'b1, r);
  endtask
endmodule

// File: test/ief_eeprom_front_end_tb_top.sv
// self-checking bench for the eeprom front end
`timescale 1ns/1ps
module ief_eeprom_front_end_tb_top;
  import ief_pkg::*;
  localparam int WC = 400;
  localparam logic [3:0] RC = 4'h5;
  localparam logic [7:0] MS = {IEF_MEM_CODE, 4'h2};
  localparam logic [7:0] RS = {RC, 4'h0};
  localparam logic [7:0] TV = {RC, 3'h0, 1'b1};
  localparam logic [7:0] AV = 8'h0c;
  localparam logic [7:0] GV = 8'h03;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic inh = 1'b0;
  logic sda_o, sda_oe_o, scl, m_oe, sda, a;
  logic [7:0] d;
  ief_stat_t stat_o;
  int failures = 0;
  int n_checks = 0;
  assign sda = !(sda_oe_o || m_oe);
  ief_eeprom_front_end #(.WRITE_CYC(WC), .REG_CODE(RC)) i_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
    .write_inhibit_pin_i(inh), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .stat_o(stat_o));
  ief_i2c_master i_mst (.sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
  always #5 core_clk_i = ~core_clk_i;
  task automatic chk(input logic [7:0] g, e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic cst(input ief_stat_t g, input logic [2:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t status %b exp %b", $time, g, e);
    end
  endtask
  task automatic sb(input logic [7:0] b, input logic e);
    i_mst.wbyte(b, a);
    chk({7'h00, a}, {7'h00, e});
  endtask
  task automatic xw(input logic [7:0] s, h, l, v, input logic e);
    i_mst.start();
    sb(s, 1'b1);
    sb(h, 1'b1);
    sb(l, 1'b1);
    sb(v, e);
    i_mst.stop();
  endtask
  task automatic xr(input logic [7:0] s, h, l, x);
    i_mst.start();
    sb(s, 1'b1);
    sb(h, 1'b1);
    sb(l, 1'b1);
    i_mst.start();
    sb(s | 8'h01, 1'b1);
    i_mst.rbyte(d);
    i_mst.stop();
    chk(d, x);
  endtask
  task automatic idle();
    cyc(8);
    for (int n = 0; n < WC + 40 && stat_o.busy !== 1'b0; n++) begin
      cyc(1);
    end
    cst(stat_o, 3'b010);
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    stop_test();
  end
  initial begin
    cyc(6);
    rst_i = 1'b0;
    cyc(1);
    cst(stat_o, 3'b010);
    cyc(IEF_WAKE_CYC);
    xw(MS, 8'h23, 8'h45, 8'h5a, 1'b1);
    cyc(8);
    cst(stat_o, 3'b100);
    i_mst.start();
    sb(MS, 1'b0);
    i_mst.stop();
    cyc(8);
    cst(stat_o, 3'b100);
    idle();
    xr(MS, 8'h23, 8'h45, 8'h5a);
    $display("done: array write");
    cyc(1);
    inh = 1'b1;
    cyc(8);
    cst(stat_o, 3'b011);
    xw(MS, 8'h23, 8'h45, 8'ha5, 1'b0);
    cyc(8);
    cst(stat_o, 3'b011);
    inh = 1'b0;
    idle();
    xr(MS, 8'h23, 8'h45, 8'h5a);
    $display("done: inhibit");
    i_mst.slow = 150;
    xr(RS, 8'he0, 8'h00, TV);
    xr(RS, 8'hff, 8'hff, TV);
    xw(RS, 8'hff, 8'h00, 8'h00, 1'b1);
    idle();
    xr(RS, 8'hf0, 8'h0f, TV);
    i_mst.slow = 0;
    i_mst.start();
    sb(8'h30, 1'b0);
    i_mst.stop();
    $display("done: type register");
    xw(RS, 8'hc0, 8'h00, AV, 1'b1);
    idle();
    xr(RS, 8'hdf, 8'hff, AV);
    xw(RS, 8'ha0, 8'h00, GV, 1'b1);
    idle();
    xr(RS, 8'hbf, 8'h00, GV);
    $display("done: config registers");
    cyc(1);
    rst_i = 1'b1;
    i_mst.start();
    sb(MS, 1'b0);
    i_mst.stop();
    cyc(1);
    rst_i = 1'b0;
    cyc(1);
    cst(stat_o, 3'b010);
    $display("done: reset");
    stop_test();
  end
endmodule
